/* tsc_pkg.sv */
/*
 * tsc_pkg: register map, field positions, reset values, timing constants and
 * indicator colour encoding for the timing module status and clock select block.
 * Assumes a 25 MHz bus clock and a backplane clock near 10 MHz.
 */
package tsc_pkg;

    localparam int HCLK_HZ = 25000000;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PFI = 8'h04;
    localparam logic [7:0] ADDR_TRIG = 8'h08;
    localparam logic [7:0] ADDR_STAR_OE = 8'h0C;
    localparam logic [7:0] ADDR_STAR_OUT = 8'h10;
    localparam logic [7:0] ADDR_SYNTH = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_TRIG_IN = 8'h1C;
    localparam logic [7:0] ADDR_STAR_IN = 8'h20;

    // control register fields
    localparam int CTRL_INIT_DONE = 0;
    localparam int CTRL_USER_AMBER = 1;
    localparam int CTRL_EXT_DIRECT = 2;
    localparam int CTRL_PLL_EXT_REF = 3;
    localparam int CTRL_CLOCK_OUTPUT_CONNECTOR_LSB = 4;
    localparam int CTRL_REPL_EN = 6;
    localparam int CTRL_STAR_EXT = 7;
    localparam int CTRL_PFI0_SYNC = 8;
    localparam int CTRL_WIDTH = 9;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h000;

    // pfi register fields
    localparam int PFI_DIR_LSB = 0;
    localparam int PFI_OUT_LSB = 8;
    // trigger register fields
    localparam int TRIG_OE_LSB = 0;
    localparam int TRIG_OUT_LSB = 8;

    // status register fields
    localparam int STAT_BP_STOPPED = 0;
    localparam int STAT_PLL_ERR = 1;
    localparam int STAT_PLL_ACTIVE = 2;
    localparam int STAT_TIMING_SLOT = 3;
    localparam int STAT_ACCESS_LSB = 4;
    localparam int STAT_ACTIVITY_LSB = 6;
    localparam int STAT_PFI_IN_LSB = 8;
    localparam int STAT_CFG_BUSY = 16;

    localparam int PFI_N = 6;
    localparam int TRIG_N = 8;
    localparam int STAR_N = 17;

    // synthesizer frequency word in hertz
    localparam int SYNTH_W = 27;
    localparam logic [SYNTH_W-1:0] SYNTH_MIN_HZ = 27'd1;
    localparam logic [SYNTH_W-1:0] SYNTH_MAX_HZ = 27'd105000000;
    localparam logic [SYNTH_W-1:0] SYNTH_RESET_HZ = 27'd10000000;

    // clock output connector source codes
    localparam logic [1:0] CLOCK_OUTPUT_CONNECTOR_OSC = 2'h0;
    localparam logic [1:0] CLOCK_OUTPUT_CONNECTOR_SYNTH = 2'h1;
    localparam logic [1:0] CLOCK_OUTPUT_CONNECTOR_BP = 2'h2;

    // access pulse length
    localparam int ACCESS_PULSE_MS = 50;
    localparam int ACCESS_PULSE_CYCLES = ACCESS_PULSE_MS * (HCLK_HZ / 1000);

    // backplane clock is declared stopped after this long without an edge
    localparam int BP_STOP_NS = 1000;
    localparam int BP_STOP_CYCLES = (BP_STOP_NS * (HCLK_HZ / 1000000) + 999) / 1000;
    localparam logic [7:0] BP_STOP_CNT = 8'(BP_STOP_CYCLES);

    typedef enum logic [1:0] {
        TSC_DARK,
        TSC_GREEN,
        TSC_AMBER,
        TSC_RED
    } tsc_colour_e;

endpackage : tsc_pkg

/* tsc_top.sv */
/*
 * tsc_top: AHB-Lite register slave, front indicators, clock source selection and
 * backplane / front pin direction control for the timing module.
 * Assumes: one AHB-Lite master with single word transfers; bp_clk is the backplane
 * 10 MHz clock, unrelated to hclk; the synthesizer, oscillator and pll sit outside.
 */
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module tsc_top
    import tsc_pkg::*;
#(
    parameter int ACCESS_PULSE_LEN = tsc_pkg::ACCESS_PULSE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic bp_clk,
    input wire logic compensated_oscillator,
    input wire logic frequency_synthesizer,
    input wire logic ext_clock_input,
    input wire logic timing_slot,
    input wire logic pll_error,
    input wire logic pll_active,
    output logic pll_ref_ext,
    output logic [tsc_pkg::SYNTH_W-1:0] synth_freq_hz,
    output logic clock_output_connector,
    output logic bp_repl_clk,
    output logic bp_repl_oe,
    output tsc_pkg::tsc_colour_e access_indicator,
    output tsc_pkg::tsc_colour_e activity_indicator,
    input wire logic [tsc_pkg::PFI_N-1:0] programmable_front_pins_in,
    output logic [tsc_pkg::PFI_N-1:0] programmable_front_pins_out,
    output logic [tsc_pkg::PFI_N-1:0] programmable_front_pins_oe,
    input wire logic [tsc_pkg::TRIG_N-1:0] trig_in,
    output logic [tsc_pkg::TRIG_N-1:0] trig_out,
    output logic [tsc_pkg::TRIG_N-1:0] trig_oe,
    input wire logic [tsc_pkg::STAR_N-1:0] star_in,
    output logic [tsc_pkg::STAR_N-1:0] star_out,
    output logic [tsc_pkg::STAR_N-1:0] star_oe
);
    import tsc_pkg::*;

    localparam int CFG_W = 2 * PFI_N + 2 * TRIG_N + 2 * STAR_N + 1;

    logic [CTRL_WIDTH-1:0] ctrl_reg;
    logic [PFI_N-1:0] pfi_dir_reg, pfi_val_reg, pfi_meta_reg, pfi_sync_reg, bp_pfi_out_reg, bp_pfi_oe_reg;
    logic [TRIG_N-1:0] trig_oe_reg, trig_val_reg, trig_meta_reg, trig_sync_reg, bp_trig_out_reg, bp_trig_oe_reg;
    logic [STAR_N-1:0] star_oe_reg, star_val_reg, star_meta_reg, star_sync_reg, bp_star_out_reg, bp_star_oe_reg;
    logic [SYNTH_W-1:0] synth_reg;
    logic [31:0] access_cnt_reg;
    logic [7:0] ph_addr_reg, bp_idle_cnt_reg;
    logic [2:0] stat_meta_reg, stat_sync_reg, bp_tog_sync_reg, req_sync_reg;
    logic [1:0] ack_sync_reg, bp_rst_reg, pfi0_sync_reg;
    logic [CFG_W-1:0] cfg_xfer_reg, bp_cfg_reg;
    logic ph_sel_reg, ph_write_reg, bp_stopped_reg, cfg_pend_reg, cfg_busy_reg, cfg_req_reg, ack_seen_reg;
    logic bp_tog_reg, cfg_ack_reg, pfi0_prev_reg;
    tsc_colour_e access_reg, activity_reg;

    logic take, wr_now, cfg_write, bp_rstn, bp_load, pfi0_rise, bp_sync_mode;
    logic [SYNTH_W-1:0] synth_next;

    // a word-aligned register read; unmapped offsets read zero
    function automatic logic [31:0] read_word(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            ADDR_CTRL: d[CTRL_WIDTH-1:0] = ctrl_reg;
            ADDR_PFI: begin
                d[PFI_DIR_LSB +: PFI_N] = pfi_dir_reg;
                d[PFI_OUT_LSB +: PFI_N] = pfi_val_reg;
            end
            ADDR_TRIG: begin
                d[TRIG_OE_LSB +: TRIG_N] = trig_oe_reg;
                d[TRIG_OUT_LSB +: TRIG_N] = trig_val_reg;
            end
            ADDR_STAR_OE: d[STAR_N-1:0] = star_oe_reg;
            ADDR_STAR_OUT: d[STAR_N-1:0] = star_val_reg;
            ADDR_SYNTH: d[SYNTH_W-1:0] = synth_reg;
            ADDR_STATUS: begin
                d[STAT_BP_STOPPED] = bp_stopped_reg;
                d[STAT_PLL_ERR] = stat_sync_reg[0];
                d[STAT_PLL_ACTIVE] = stat_sync_reg[1];
                d[STAT_TIMING_SLOT] = stat_sync_reg[2];
                d[STAT_ACCESS_LSB +: 2] = access_reg;
                d[STAT_ACTIVITY_LSB +: 2] = activity_reg;
                d[STAT_PFI_IN_LSB +: PFI_N] = pfi_sync_reg;
                d[STAT_CFG_BUSY] = cfg_busy_reg | cfg_pend_reg;
            end
            ADDR_TRIG_IN: d[TRIG_N-1:0] = trig_sync_reg;
            ADDR_STAR_IN: d[STAR_N-1:0] = star_sync_reg;
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction : read_word

    // bus slave: zero wait states, always OKAY
    assign take = hsel & htrans[1] & hready;
    assign wr_now = ph_sel_reg & ph_write_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_sel_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else begin
            ph_sel_reg <= take;
            ph_write_reg <= hwrite;
            ph_addr_reg <= {haddr[7:2], 2'b00};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= read_word({haddr[7:2], 2'b00});
        end
    end

    // out-of-range synthesizer words are clamped, not rejected
    always_comb begin
        synth_next = hwdata[SYNTH_W-1:0];
        if (synth_next < SYNTH_MIN_HZ) begin
            synth_next = SYNTH_MIN_HZ;
        end else if (synth_next > SYNTH_MAX_HZ) begin
            synth_next = SYNTH_MAX_HZ;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= CTRL_RESET;
            pfi_dir_reg <= '0;
            pfi_val_reg <= '0;
            trig_oe_reg <= '0;
            trig_val_reg <= '0;
            star_oe_reg <= '0;
            star_val_reg <= '0;
            synth_reg <= SYNTH_RESET_HZ;
        end else if (wr_now) begin
            case (ph_addr_reg)
                ADDR_CTRL: ctrl_reg <= hwdata[CTRL_WIDTH-1:0];
                ADDR_PFI: begin
                    pfi_dir_reg <= hwdata[PFI_DIR_LSB +: PFI_N];
                    pfi_val_reg <= hwdata[PFI_OUT_LSB +: PFI_N];
                end
                ADDR_TRIG: begin
                    trig_oe_reg <= hwdata[TRIG_OE_LSB +: TRIG_N];
                    trig_val_reg <= hwdata[TRIG_OUT_LSB +: TRIG_N];
                end
                ADDR_STAR_OE: star_oe_reg <= hwdata[STAR_N-1:0];
                ADDR_STAR_OUT: star_val_reg <= hwdata[STAR_N-1:0];
                ADDR_SYNTH: synth_reg <= synth_next;
                default: ;
            endcase
        end
    end

    assign synth_freq_hz = synth_reg;

    // any write that changes pin setup queues a transfer to the link side
    assign cfg_write = wr_now && (ph_addr_reg == ADDR_CTRL || ph_addr_reg == ADDR_PFI ||
        ph_addr_reg == ADDR_TRIG || ph_addr_reg == ADDR_STAR_OE || ph_addr_reg == ADDR_STAR_OUT);

    // a write landing as the pending flag is consumed keeps it set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_pend_reg <= 1'b1;
        end else if (cfg_write) begin
            cfg_pend_reg <= 1'b1;
        end else if (!cfg_busy_reg) begin
            cfg_pend_reg <= 1'b0;
        end
    end

    // toggle handshake; the word is held stable until the ack returns
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_busy_reg <= 1'b0;
            cfg_req_reg <= 1'b0;
            cfg_xfer_reg <= '0;
            ack_sync_reg <= 2'b00;
            ack_seen_reg <= 1'b0;
        end else begin
            ack_sync_reg <= {ack_sync_reg[0], cfg_ack_reg};
            if (cfg_busy_reg) begin
                if (ack_sync_reg[1] != ack_seen_reg) begin
                    ack_seen_reg <= ack_sync_reg[1];
                    cfg_busy_reg <= 1'b0;
                end
            end else if (cfg_pend_reg) begin
                cfg_xfer_reg <= {ctrl_reg[CTRL_PFI0_SYNC], star_oe_reg, star_val_reg,
                    trig_oe_reg, trig_val_reg, pfi_dir_reg, pfi_val_reg};
                cfg_req_reg <= ~cfg_req_reg;
                cfg_busy_reg <= 1'b1;
            end
        end
    end

    // pins and status levels enter hclk through two flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_meta_reg <= 3'h0;
            stat_sync_reg <= 3'h0;
            pfi_meta_reg <= '0;
            pfi_sync_reg <= '0;
            trig_meta_reg <= '0;
            trig_sync_reg <= '0;
            star_meta_reg <= '0;
            star_sync_reg <= '0;
        end else begin
            stat_meta_reg <= {timing_slot, pll_active, pll_error};
            stat_sync_reg <= stat_meta_reg;
            pfi_meta_reg <= programmable_front_pins_in;
            pfi_sync_reg <= pfi_meta_reg;
            trig_meta_reg <= trig_in;
            trig_sync_reg <= trig_meta_reg;
            star_meta_reg <= star_in;
            star_sync_reg <= star_meta_reg;
        end
    end

    // backplane clock watchdog: a toggle from bp_clk must keep changing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bp_tog_sync_reg <= 3'h0;
            bp_idle_cnt_reg <= 8'h00;
            bp_stopped_reg <= 1'b1;
        end else begin
            bp_tog_sync_reg <= {bp_tog_sync_reg[1:0], bp_tog_reg};
            if (bp_tog_sync_reg[2] != bp_tog_sync_reg[1]) begin
                bp_idle_cnt_reg <= 8'h00;
                bp_stopped_reg <= 1'b0;
            end else if (bp_idle_cnt_reg >= BP_STOP_CNT) begin
                bp_stopped_reg <= 1'b1;
            end else begin
                bp_idle_cnt_reg <= bp_idle_cnt_reg + 8'h01;
            end
        end
    end

    // access pulse timer, reloaded on every taken transfer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            access_cnt_reg <= 32'h0000_0000;
        end else if (take) begin
            access_cnt_reg <= 32'(ACCESS_PULSE_LEN);
        end else if (access_cnt_reg != 32'h0000_0000) begin
            access_cnt_reg <= access_cnt_reg - 32'h0000_0001;
        end
    end

    // registered priority encoders for both indicators
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            access_reg <= TSC_DARK;
        end else if (!ctrl_reg[CTRL_INIT_DONE]) begin
            access_reg <= TSC_DARK;
        end else if (access_cnt_reg != 32'h0000_0000) begin
            access_reg <= TSC_AMBER;
        end else begin
            access_reg <= TSC_GREEN;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            activity_reg <= TSC_DARK;
        end else if (bp_stopped_reg || stat_sync_reg[0]) begin
            activity_reg <= TSC_RED;
        end else if (ctrl_reg[CTRL_USER_AMBER]) begin
            activity_reg <= TSC_AMBER;
        end else if (stat_sync_reg[1]) begin
            activity_reg <= TSC_GREEN;
        end else begin
            activity_reg <= TSC_DARK;
        end
    end

    assign access_indicator = access_reg;
    assign activity_indicator = activity_reg;

    // clock steering; select changes may glitch the output, so software should
    // switch sources only while downstream users are idle
    always_comb begin
        case (ctrl_reg[CTRL_CLOCK_OUTPUT_CONNECTOR_LSB +: 2])
            CLOCK_OUTPUT_CONNECTOR_OSC: clock_output_connector = compensated_oscillator;
            CLOCK_OUTPUT_CONNECTOR_SYNTH: clock_output_connector = frequency_synthesizer;
            CLOCK_OUTPUT_CONNECTOR_BP: clock_output_connector = bp_clk;
            default: clock_output_connector = 1'b0;
        endcase
    end

    assign bp_repl_clk = ctrl_reg[CTRL_EXT_DIRECT] ? ext_clock_input : compensated_oscillator;
    assign bp_repl_oe = ctrl_reg[CTRL_REPL_EN] & stat_sync_reg[2];
    assign pll_ref_ext = ctrl_reg[CTRL_PLL_EXT_REF] & ~ctrl_reg[CTRL_EXT_DIRECT];

    // link side: reset asserted asynchronously, released on bp_clk
    always_ff @(posedge bp_clk or negedge hresetn) begin
        if (!hresetn) begin
            bp_rst_reg <= 2'b00;
        end else begin
            bp_rst_reg <= {bp_rst_reg[0], 1'b1};
        end
    end
    assign bp_rstn = bp_rst_reg[1];

    always_ff @(posedge bp_clk or negedge bp_rstn) begin
        if (!bp_rstn) begin
            bp_tog_reg <= 1'b0;
            req_sync_reg <= 3'h0;
            cfg_ack_reg <= 1'b0;
            bp_cfg_reg <= '0;
            pfi0_sync_reg <= 2'b00;
            pfi0_prev_reg <= 1'b0;
        end else begin
            bp_tog_reg <= ~bp_tog_reg;
            req_sync_reg <= {req_sync_reg[1:0], cfg_req_reg};
            if (req_sync_reg[2] != req_sync_reg[1]) begin
                bp_cfg_reg <= cfg_xfer_reg;
                cfg_ack_reg <= req_sync_reg[1];
            end
            pfi0_sync_reg <= {pfi0_sync_reg[0], programmable_front_pins_in[0]};
            pfi0_prev_reg <= pfi0_sync_reg[1];
        end
    end

    assign bp_sync_mode = bp_cfg_reg[CFG_W-1];
    assign pfi0_rise = pfi0_sync_reg[1] & ~pfi0_prev_reg;
    // in sync mode routed outputs advance only on a pin zero rising edge
    assign bp_load = bp_sync_mode ? pfi0_rise : 1'b1;

    always_ff @(posedge bp_clk or negedge bp_rstn) begin
        if (!bp_rstn) begin
            bp_pfi_out_reg <= '0;
            bp_pfi_oe_reg <= '0;
            bp_trig_out_reg <= '0;
            bp_trig_oe_reg <= '0;
            bp_star_out_reg <= '0;
            bp_star_oe_reg <= '0;
        end else begin
            bp_pfi_oe_reg <= bp_cfg_reg[PFI_N +: PFI_N] & {{(PFI_N-1){1'b1}}, ~bp_sync_mode};
            bp_trig_oe_reg <= bp_cfg_reg[2*PFI_N + TRIG_N +: TRIG_N];
            bp_star_oe_reg <= bp_cfg_reg[2*PFI_N + 2*TRIG_N + STAR_N +: STAR_N];
            if (bp_load) begin
                bp_pfi_out_reg <= bp_cfg_reg[0 +: PFI_N];
                bp_trig_out_reg <= bp_cfg_reg[2*PFI_N +: TRIG_N];
                bp_star_out_reg <= bp_cfg_reg[2*PFI_N + 2*TRIG_N +: STAR_N];
            end
        end
    end

    assign programmable_front_pins_out = bp_pfi_out_reg;
    assign programmable_front_pins_oe = bp_pfi_oe_reg;
    assign trig_out = bp_trig_out_reg;
    assign trig_oe = bp_trig_oe_reg;
    // star lines may carry the raw external clock instead of registered data
    assign star_out = ctrl_reg[CTRL_STAR_EXT] ? {STAR_N{ext_clock_input}} : bp_star_out_reg;
    assign star_oe = bp_star_oe_reg & {STAR_N{stat_sync_reg[2]}};

endmodule : tsc_top

/* tsc_chk.sv */
/* tsc_chk: assertions on the tsc_top ports, bus clock domain only.
   bound from the bench top; the pulse length parameter is handed on by the bind. */
`timescale 1ns/100ps
module tsc_chk #(
    parameter int ACCESS_PULSE_LEN = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hwrite,
    input wire logic pll_error,
    input wire logic pll_active,
    input wire logic timing_slot,
    input wire logic compensated_oscillator,
    input wire logic pll_ref_ext,
    input wire logic bp_repl_clk,
    input wire logic bp_repl_oe,
    input wire logic [tsc_pkg::SYNTH_W-1:0] synth_freq_hz,
    input tsc_pkg::tsc_colour_e access_indicator,
    input tsc_pkg::tsc_colour_e activity_indicator
);
    import tsc_pkg::*;
    logic [7:0] since_take;
    // saturates so a long idle spell cannot wrap back into the pulse window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_take <= 8'hFF;
        end else if (hsel && htrans[1] && hready) begin
            since_take <= 8'h00;
        end else if (since_take != 8'hFF) begin
            since_take <= since_take + 8'h01;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    err_red_a: assert property (pll_error [*4] |-> activity_indicator == TSC_RED)
        else $error("activity not red on pll error");
    amber_err_a: assert property (activity_indicator == TSC_AMBER
        |-> !$past(pll_error, 3)) else $error("amber shown over pll error");
    pll_green_a: assert property (activity_indicator == TSC_GREEN
        |-> $past(pll_active, 3) && !$past(pll_error, 3)) else $error("green without active pll");
    read_amber_a: assert property (hsel && htrans[1] && hready && !hwrite && access_indicator != TSC_DARK
        |-> ##2 (access_indicator == TSC_AMBER) [*8]) else $error("read did not light amber");
    pulse_len_a: assert property (access_indicator == TSC_AMBER
        |-> since_take <= ACCESS_PULSE_LEN + 2) else $error("amber outlasts last access");
    repl_slot_a: assert property (bp_repl_oe
        |-> $past(timing_slot, 2) || $past(timing_slot, 3)) else $error("replacement driven off slot");
    ext_ref_a: assert property (pll_ref_ext
        |-> bp_repl_clk == compensated_oscillator) else $error("external reference with direct feed");
    synth_range_a: assert property (synth_freq_hz >= SYNTH_MIN_HZ && synth_freq_hz <= SYNTH_MAX_HZ)
        else $error("synthesizer word out of range");
endmodule : tsc_chk

/* tsc_bp_model.sv */
/* tsc_bp_model: chassis side, a free running backplane clock and the other slots on shared lines.
   run comes from the bench and stops the clock for the stall case. */
`timescale 1ns/100ps
module tsc_bp_model (
    input wire logic run,
    input wire logic [7:0] trig_out,
    input wire logic [7:0] trig_oe,
    input wire logic [16:0] star_out,
    input wire logic [16:0] star_oe,
    output logic bp_clk,
    output logic [7:0] trig_in,
    output logic [16:0] star_in
);
    logic [7:0] other = 8'h5A;
    initial begin
        bp_clk = 1'b0;
        #7;
        forever begin
            #40 bp_clk = run ? ~bp_clk : bp_clk;
        end
    end
    // other slots flip the lines they own so a stale level never matches
    always @(posedge bp_clk) other <= ~other;
    assign trig_in = (trig_oe & trig_out) | (~trig_oe & other);
    assign star_in = (star_oe & star_out) | (~star_oe & {other, other, other[0]});
endmodule : tsc_bp_model

/* tb_timing_module_status_and_clock_select.sv */
/* tb_timing_module_status_and_clock_select: self-checking bench for tsc_top.
   chassis side from tsc_bp_model; assertions from tsc_chk, bound at the foot. */
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_timing_module_status_and_clock_select;
    import tsc_pkg::*;
    localparam int LEN = 20;
    int seed = 88583, mismatches = 0, check_count = 0;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, run = 1'b1, timing_slot = 1'b1;
    logic pll_error = 1'b0, pll_active = 1'b0, compensated_oscillator = 1'b0, frequency_synthesizer = 1'b0;
    logic ext_clock_input = 1'b0, hready, hreadyout, hresp, bp_clk, pll_ref_ext, bp_repl_clk, bp_repl_oe;
    logic clock_output_connector;
    logic [3:0] src;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, pv, tv, so, sv;
    logic [SYNTH_W-1:0] synth_freq_hz;
    tsc_colour_e access_indicator, activity_indicator;
    logic [PFI_N-1:0] programmable_front_pins_in, programmable_front_pins_out, programmable_front_pins_oe;
    logic [PFI_N-1:0] pfi_drv = 6'h00;
    logic [TRIG_N-1:0] trig_in, trig_out, trig_oe;
    logic [STAR_N-1:0] star_in, star_out, star_oe;
    assign hready = hreadyout;
    // expected connector level per select code; code 3 holds the output low
    assign src = {1'b0, bp_clk, frequency_synthesizer, compensated_oscillator};
    // the far end drives a front pin only where the block does not
    assign programmable_front_pins_in = (programmable_front_pins_oe & programmable_front_pins_out)
        | (~programmable_front_pins_oe & pfi_drv);
    tsc_top #(.ACCESS_PULSE_LEN(LEN)) tsc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .bp_clk, .compensated_oscillator, .frequency_synthesizer,
        .ext_clock_input, .timing_slot, .pll_error, .pll_active, .pll_ref_ext, .synth_freq_hz,
        .clock_output_connector, .bp_repl_clk, .bp_repl_oe, .access_indicator, .activity_indicator,
        .programmable_front_pins_in, .programmable_front_pins_out, .programmable_front_pins_oe,
        .trig_in, .trig_out, .trig_oe, .star_in, .star_out, .star_oe);
    tsc_bp_model tsc_bp_model_i (.run, .trig_out, .trig_oe, .star_out, .star_oe, .bp_clk, .trig_in, .star_in);
    initial begin
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        {compensated_oscillator, frequency_synthesizer, ext_clock_input, pfi_drv} <= 9'($random(seed));
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
        #5;
    endtask : cyc
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    function automatic logic [26:0] clamp(input logic [31:0] v);
        return v < 32'h1 ? SYNTH_MIN_HZ : v > SYNTH_MAX_HZ ? SYNTH_MAX_HZ : v[26:0];
    endfunction : clamp
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #200000;
        mismatches++;
        test_done();
    end
    initial begin
        cyc(5);
        hresetn <= 1'b1;
        cyc(30);
        bus(1'b0, 8'h3C, 32'h0);
        `CHK(rd, 32'h0)
        cyc(4);
        `CHK(access_indicator, TSC_DARK)
        pll_active <= 1'b1;
        bus(1'b1, ADDR_CTRL, 32'h1);
        cyc(LEN + 6);
        `CHK(access_indicator, TSC_GREEN)
        `CHK(activity_indicator, TSC_GREEN)
        bus(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[STAT_ACTIVITY_LSB +: 2], TSC_GREEN)
        `CHK(hresp, 1'b0)
        cyc(9);
        bus(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[STAT_ACCESS_LSB +: 2], TSC_AMBER)
        cyc(14);
        `CHK(access_indicator, TSC_AMBER)
        cyc(12);
        `CHK(access_indicator, TSC_GREEN)
        bus(1'b1, ADDR_CTRL, 32'h3);
        cyc(3);
        `CHK(activity_indicator, TSC_AMBER)
        pll_error <= 1'b1;
        cyc(5);
        `CHK(activity_indicator, TSC_RED)
        pll_error <= 1'b0;
        run <= 1'b0;
        cyc(40);
        `CHK(activity_indicator, TSC_RED)
        run <= 1'b1;
        cyc(10);
        `CHK(activity_indicator, TSC_AMBER)
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, ADDR_CTRL, 32'h1 | (s << 4));
            repeat (8) begin
                cyc(1);
                `CHK(clock_output_connector, src[s])
            end
        end
        bus(1'b1, ADDR_CTRL, 32'h45);
        cyc(1);
        `CHK(bp_repl_clk, ext_clock_input)
        `CHK(pll_ref_ext, 1'b0)
        bus(1'b1, ADDR_CTRL, 32'h49);
        cyc(1);
        `CHK(bp_repl_clk, compensated_oscillator)
        `CHK(pll_ref_ext, 1'b1)
        bus(1'b1, ADDR_CTRL, 32'h4D);
        cyc(1);
        `CHK(pll_ref_ext, 1'b0)
        for (int n = 0; n < 4; n++) begin
            pv = $random(seed);
            tv = $random(seed);
            so = $random(seed);
            sv = $random(seed);
            timing_slot <= n[0];
            bus(1'b1, ADDR_PFI, pv);
            bus(1'b1, ADDR_TRIG, tv);
            bus(1'b1, ADDR_STAR_OE, so);
            bus(1'b1, ADDR_STAR_OUT, sv);
            cyc(30);
            `CHK(bp_repl_oe, n[0])
            `CHK(programmable_front_pins_oe, pv[5:0])
            `CHK(programmable_front_pins_out, pv[13:8])
            `CHK(trig_oe, tv[7:0])
            `CHK(trig_out, tv[15:8])
            `CHK(star_oe, so[16:0] & {STAR_N{n[0]}})
            `CHK(star_out, sv[16:0])
            bus(1'b0, ADDR_TRIG_IN, 32'h0);
            `CHK(rd[7:0] & tv[7:0], tv[15:8] & tv[7:0])
            bus(1'b0, ADDR_STAR_IN, 32'h0);
            `CHK(rd[16:0] & so[16:0] & {STAR_N{n[0]}}, sv[16:0] & so[16:0] & {STAR_N{n[0]}})
        end
        bus(1'b1, ADDR_PFI, 32'h3F);
        bus(1'b1, ADDR_CTRL, 32'h181);
        cyc(30);
        `CHK(star_out, {STAR_N{ext_clock_input}})
        `CHK(programmable_front_pins_oe, 6'h3E)
        for (int i = 0; i < 6; i++) begin
            sv = i == 0 ? 32'h0 : i == 1 ? 32'd120000000 : i == 2 ? 32'd105000000 : i == 3 ? 32'h1 : $random(seed);
            sv = sv & 32'h07FFFFFF;
            bus(1'b1, ADDR_SYNTH, sv);
            bus(1'b0, ADDR_SYNTH, 32'h0);
            `CHK(rd[26:0], clamp(sv))
            `CHK(synth_freq_hz, clamp(sv))
        end
        test_done();
    end
endmodule : tb_timing_module_status_and_clock_select
bind tsc_top tsc_chk #(.ACCESS_PULSE_LEN(ACCESS_PULSE_LEN)) tsc_chk_i (.hclk, .hresetn, .hsel, .htrans, .hready,
    .hwrite, .pll_error, .pll_active, .timing_slot, .compensated_oscillator, .pll_ref_ext, .bp_repl_clk,
    .bp_repl_oe, .synth_freq_hz, .access_indicator, .activity_indicator);
